// file: dlm_defs.svh
// dlm_defs.svh - constants of the device and link control mirror:
// dword offsets, field positions, the ASPM L0s code and reset values.
// assumes it is included by its bare name after `default_nettype none.
`ifndef DLM_DEFS_SVH
`define DLM_DEFS_SVH

// ----------------------------------------------------------------------
// base dword of the capability and dword offsets inside it, added to that base
// ----------------------------------------------------------------------
`define DLM_CAP_BASE_DW     7'h1C
`define DLM_DEVCTRL_DW      7'h02
`define DLM_LINK_CONTROL_REG_DW     7'h04
`define DLM_DEVCTRL2_DW     7'h0A

// ----------------------------------------------------------------------
// field positions inside the written dword and the ASPM L0s code
// ----------------------------------------------------------------------
`define DLM_DEVCTRL_MSB     14
`define DLM_STATUS_LSB      16
`define DLM_STATUS_MSB      19
`define DLM_LC_ASPM_MSB     1
`define DLM_LC_COMMON_BIT   6
`define DLM_LC_EXTSYNC_BIT  7
`define DLM_LC_CLKPM_BIT    8
`define DLM_LC_BWINT_BIT    10
`define DLM_LC_AUTOBW_BIT   11
`define DLM_DC2_IDOREQ_BIT  8
`define DLM_DC2_LTR_BIT     10
`define DLM_DC2_PREFIX_BIT  15
`define DLM_ASPM_L0S        2'h1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DLM_DEVCTRL_RST     15'h2810
`define DLM_LINK_CONTROL_REG_RST    7'h00
`define DLM_DEVCTRL2_RST    3'h0
`define DLM_STATUS_RST      4'h0

`endif

// file: dlm_link_control_mirror.sv
// dlm_link_control_mirror.sv - holds the device control, device status,
// link control and device control 2 fields and mirrors them to user logic;
// logs error events and requests error messages.
// assumes write strobes, error events and link state come from logic on
// ref_clk, so none of them is synchronised here.
`timescale 1ns/1ns
`default_nettype none
`include "dlm_defs.svh"

// Functional notes
// - latency report enable resets to zero
// - error report enables gate error messages
// - root port never emits error messages
// - tag width is never checked here
// - UR enable gates UR error messages
// - status logged regardless of report enables
// - UR status shows a received UR
// - ASPM code 01 enables L0s entry
// - common clock bit mirrored to user
// - extended synch forces extra ordered sets
module dlm_link_control_mirror #(
  parameter logic [6:0] CAP_BASE_DW = `DLM_CAP_BASE_DW  // capability base
) (
  input  wire logic                   ref_clk,          // 20 MHz clock
  input  wire logic                   arst_n,           // async reset
  input  wire dlm_pkg::dlm_cfg_wr_s   cfgWr,            // config write
  input  wire dlm_pkg::dlm_err_s      errEvent,         // error pulses
  input  wire logic                   rootPortMode,     // root port use
  input  wire logic                   linkExitingL0s,   // leaving L0s
  input  wire logic                   linkInRecovery,   // in Recovery
  output logic                        idOrderRequestEnable, // IDO mirror
  output logic                        latencyReportEnable,  // LTR mirror
  output logic                        prefixForwardBlock,   // prefix block
  output dlm_pkg::dlm_dev_ctrl_s      devCtrl,          // device control
  output dlm_pkg::dlm_err_s           devStatus,        // device status
  output dlm_pkg::dlm_link_ctrl_s     link_control_reg,         // link control
  output dlm_pkg::dlm_msg_s           errMsgSend,       // message pulses
  output logic                        l0sEntryAllowed,  // ASPM decoded
  output logic                        extraOrderedSets  // force extra OS
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------

  // true when a valid write hits the given dword of the capability
  function automatic logic hitsDw(input dlm_pkg::dlm_cfg_wr_s wr,
                                  input logic [6:0] base,
                                  input logic [6:0] rel);
    hitsDw = wr.valid && (wr.dwAddr == 7'(base + rel));
  endfunction

  // merge the low sixteen bits of a write into an old value by byte lane
  function automatic logic [15:0] mergeLow(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  be);
    mergeLow[7:0]  = be[0] ? data[7:0]  : old[7:0];
    mergeLow[15:8] = be[1] ? data[15:8] : old[15:8];
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  dlm_pkg::dlm_dev_ctrl_s  devCtrl_q,   devCtrl_d;
  dlm_pkg::dlm_err_s       status_q,    status_d;
  dlm_pkg::dlm_link_ctrl_s link_control_reg_q,  link_control_reg_d;
  dlm_pkg::dlm_dev_ctrl2_s devCtrl2_q,  devCtrl2_d;
  dlm_pkg::dlm_msg_s       msg_q,       msg_d;
  logic                    l0sOk_q,     l0sOk_d;
  logic                    extraOs_q,   extraOs_d;

  logic                    hitDevCtrl;
  logic                    hitLinkCtrl;
  logic                    hitDevCtrl2;
  logic [15:0]             mergedLow;
  logic [3:0]              statusClr;

  // write decode shared by the next-state logic and the checks
  assign hitDevCtrl  = hitsDw(cfgWr, CAP_BASE_DW, `DLM_DEVCTRL_DW);
  assign hitLinkCtrl = hitsDw(cfgWr, CAP_BASE_DW, `DLM_LINK_CONTROL_REG_DW);
  assign hitDevCtrl2 = hitsDw(cfgWr, CAP_BASE_DW, `DLM_DEVCTRL2_DW);

  // ----------------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------------

  // register updates on writes, status logging and message requests
  always_comb begin
    devCtrl_d  = devCtrl_q;
    link_control_reg_d = link_control_reg_q;
    devCtrl2_d = devCtrl2_q;
    mergedLow  = 16'h0000;
    statusClr  = 4'h0;
    // device control takes byte lanes 0 and 1; aux power stays zero
    if (hitDevCtrl) begin
      mergedLow = mergeLow({1'b0, devCtrl_q}, cfgWr.data, cfgWr.byteEn);
      devCtrl_d = dlm_pkg::dlm_dev_ctrl_s'(mergedLow[`DLM_DEVCTRL_MSB:0]);
      devCtrl_d.auxPowerEnableOut = 1'b0;
      if (cfgWr.byteEn[2]) begin
        statusClr = cfgWr.data[`DLM_STATUS_MSB:`DLM_STATUS_LSB];
      end
    end
    // link control: lane 0 holds ASPM, common clock and extended synch, lane 1 the rest
    if (hitLinkCtrl) begin
      if (cfgWr.byteEn[0]) begin
        link_control_reg_d.activePowerMgmtControl =
          cfgWr.data[`DLM_LC_ASPM_MSB:0];
        link_control_reg_d.sharedRefclkConfig =
          cfgWr.data[`DLM_LC_COMMON_BIT];
        link_control_reg_d.extendedSynchOut = cfgWr.data[`DLM_LC_EXTSYNC_BIT];
      end
      if (cfgWr.byteEn[1]) begin
        link_control_reg_d.clockPowerMgmtEnable =
          cfgWr.data[`DLM_LC_CLKPM_BIT];
        link_control_reg_d.bwMgmtIrqEnable = cfgWr.data[`DLM_LC_BWINT_BIT];
        link_control_reg_d.autonomousBwIrqEnable =
          cfgWr.data[`DLM_LC_AUTOBW_BIT];
      end
    end
    // device control 2 bits all sit in byte lane 1
    if (hitDevCtrl2 && cfgWr.byteEn[1]) begin
      devCtrl2_d.idOrderRequestEnable = cfgWr.data[`DLM_DC2_IDOREQ_BIT];
      devCtrl2_d.latencyReportEnable  = cfgWr.data[`DLM_DC2_LTR_BIT];
      devCtrl2_d.prefixForwardBlock   = cfgWr.data[`DLM_DC2_PREFIX_BIT];
    end
    // status is write-one-to-clear; a new event beats the clear
    status_d = dlm_pkg::dlm_err_s'((status_q & ~statusClr)
                                   | errEvent);
    // messages need the enable and never leave a root port
    msg_d.correctable = errEvent.correctableSeenStatus
                        && devCtrl_q.correctableReportEnable
                        && !rootPortMode;
    msg_d.fatal = errEvent.fatalSeenStatus
                  && devCtrl_q.fatalReportEnable
                  && !rootPortMode;
    // an unsupported request goes out as a non-fatal message
    msg_d.nonfatal = ((errEvent.nonfatalSeenStatus
                       && devCtrl_q.nonfatalReportEnable)
                      || (errEvent.unsupportedSeenStatus
                          && devCtrl_q.unsupportedReportEnable
                          && devCtrl_q.nonfatalReportEnable))
                     && !rootPortMode;
    // codes 10 and 11 are unused and enable nothing
    l0sOk_d = (link_control_reg_q.activePowerMgmtControl == `DLM_ASPM_L0S);
    // extra ordered sets on L0s exit and throughout Recovery
    extraOs_d = link_control_reg_q.extendedSynchOut
                && (linkExitingL0s || linkInRecovery);
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------

  // all mirrors start from their defaults
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      devCtrl_q  <= dlm_pkg::dlm_dev_ctrl_s'(`DLM_DEVCTRL_RST);
      status_q   <= dlm_pkg::dlm_err_s'(`DLM_STATUS_RST);
      link_control_reg_q <= dlm_pkg::dlm_link_ctrl_s'(`DLM_LINK_CONTROL_REG_RST);
      devCtrl2_q <= dlm_pkg::dlm_dev_ctrl2_s'(`DLM_DEVCTRL2_RST);
      msg_q      <= 3'h0;
      l0sOk_q    <= 1'b0;
      extraOs_q  <= 1'b0;
    end else begin
      devCtrl_q  <= devCtrl_d;
      status_q   <= status_d;
      link_control_reg_q <= link_control_reg_d;
      devCtrl2_q <= devCtrl2_d;
      msg_q      <= msg_d;
      l0sOk_q    <= l0sOk_d;
      extraOs_q  <= extraOs_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------

  // user logic bounds its attributes, tags and sizes by these mirrors;
  // tag width is not policed here at all
  assign devCtrl              = devCtrl_q;
  assign devStatus            = status_q;
  assign link_control_reg             = link_control_reg_q;
  assign idOrderRequestEnable = devCtrl2_q.idOrderRequestEnable;
  assign latencyReportEnable  = devCtrl2_q.latencyReportEnable;
  assign prefixForwardBlock   = devCtrl2_q.prefixForwardBlock;
  assign errMsgSend           = msg_q;
  assign l0sEntryAllowed      = l0sOk_q;
  assign extraOrderedSets     = extraOs_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // a logged unsupported request shows next cycle and holds without clear
  sequence urLogged;
    ##1 devStatus.unsupportedSeenStatus;
  endsequence

  sequence urHeld;
    ##1 (devStatus.unsupportedSeenStatus && !hitDevCtrl) [*2];
  endsequence

  chk_ltr_only_write: assert property (
    $rose(latencyReportEnable) |-> $past(hitDevCtrl2)
      && $past(cfgWr.data[`DLM_DC2_LTR_BIT]))
    else $error("latency report enable rose without a write");

  chk_status_logged: assert property (
    errEvent.fatalSeenStatus |=> devStatus.fatalSeenStatus)
    else $error("fatal event not logged");

  chk_ur_status_set: assert property (
    errEvent.unsupportedSeenStatus |-> urLogged)
    else $error("unsupported request not logged");

  chk_ur_status_hold: assert property (
    (errEvent.unsupportedSeenStatus && !hitDevCtrl) ##1 !hitDevCtrl
      |-> devStatus.unsupportedSeenStatus)
    else $error("unsupported status lost without clear");

  chk_corr_msg_sent: assert property (
    (errEvent.correctableSeenStatus && devCtrl.correctableReportEnable
      && !rootPortMode) |=> errMsgSend.correctable)
    else $error("correctable message missing");

  chk_root_no_msg: assert property (
    rootPortMode |=> (errMsgSend == 3'h0))
    else $error("root port emitted an error message");

  chk_ur_msg_gate: assert property (
    (errEvent.unsupportedSeenStatus && !devCtrl.unsupportedReportEnable
      && !errEvent.nonfatalSeenStatus) |=> !errMsgSend.nonfatal)
    else $error("unsupported request reported while disabled");

  chk_aspm_decode: assert property (
    ##1 (l0sEntryAllowed ==
      ($past(link_control_reg.activePowerMgmtControl) == `DLM_ASPM_L0S)))
    else $error("L0s entry decode wrong");

  chk_common_clock: assert property (
    (hitLinkCtrl && cfgWr.byteEn[0]) |=>
      (link_control_reg.sharedRefclkConfig == $past(cfgWr.data[`DLM_LC_COMMON_BIT])))
    else $error("common clock mirror not updated");

  chk_ext_synch: assert property (
    (link_control_reg.extendedSynchOut && linkInRecovery) |=> extraOrderedSets)
    else $error("extra ordered sets not forced in Recovery");

  chk_mirror_stable: assert property (
    !hitDevCtrl2 |=> $stable(prefixForwardBlock)
      && $stable(idOrderRequestEnable))
    else $error("control 2 mirror changed without a write");

  chk_fatal_msg_sent: assert property (
    (errEvent.fatalSeenStatus && devCtrl.fatalReportEnable
      && !rootPortMode) |=> errMsgSend.fatal)
    else $error("fatal message missing");

  chk_nonfatal_msg: assert property (
    (errEvent.nonfatalSeenStatus && devCtrl.nonfatalReportEnable
      && !rootPortMode) |=> errMsgSend.nonfatal)
    else $error("non-fatal message missing");

  chk_ur_msg_sent: assert property (
    (errEvent.unsupportedSeenStatus && devCtrl.unsupportedReportEnable
      && devCtrl.nonfatalReportEnable && !rootPortMode)
      |=> errMsgSend.nonfatal)
    else $error("unsupported request message missing");

  chk_msg_has_cause: assert property (
    errMsgSend.correctable |-> $past(errEvent.correctableSeenStatus
      && devCtrl.correctableReportEnable))
    else $error("correctable message without an enabled event");

  chk_all_logged: assert property (
    (errEvent != 4'h0) |=>
      ((devStatus & $past(errEvent)) == $past(errEvent)))
    else $error("error event not logged in status");

  chk_ur_status_clear: assert property (
    (hitDevCtrl && cfgWr.byteEn[2] && cfgWr.data[`DLM_STATUS_MSB]
      && !errEvent.unsupportedSeenStatus)
      |=> !devStatus.unsupportedSeenStatus)
    else $error("unsupported status not cleared");

  chk_aux_power_zero: assert property (
    !devCtrl.auxPowerEnableOut)
    else $error("aux power mirror not zero");

  chk_synch_mirror_write: assert property (
    (hitLinkCtrl && cfgWr.byteEn[0]) |=>
      (link_control_reg.extendedSynchOut == $past(cfgWr.data[`DLM_LC_EXTSYNC_BIT])))
    else $error("extended synch mirror not updated");

  chk_synch_l0s_exit: assert property (
    (link_control_reg.extendedSynchOut && linkExitingL0s) |=> extraOrderedSets)
    else $error("extra ordered sets not forced on L0s exit");

endmodule // dlm_link_control_mirror

`default_nettype wire

// file: dlm_pkg.sv
// dlm_pkg.sv - types of the device and link control mirror.
// assumes nothing; holds types only, constants live in dlm_defs.svh.
`default_nettype none

package dlm_pkg;

  // device control field, laid out as its bits 14:0
  typedef struct packed {
    logic [2:0] maxReadRequestSize;      // 14:12
    logic       noSnoopEnable;           // 11
    logic       auxPowerEnableOut;       // 10
    logic       phantomFunctionEnable;   // 9
    logic       wideTagEnable;           // 8
    logic [2:0] maxPayloadSize;          // 7:5
    logic       relaxedOrderEnable;      // 4
    logic       unsupportedReportEnable; // 3
    logic       fatalReportEnable;       // 2
    logic       nonfatalReportEnable;    // 1
    logic       correctableReportEnable; // 0
  } dlm_dev_ctrl_s;

  // device status error bits, also used for incoming error events
  typedef struct packed {
    logic unsupportedSeenStatus; // 3
    logic fatalSeenStatus;       // 2
    logic nonfatalSeenStatus;    // 1
    logic correctableSeenStatus; // 0
  } dlm_err_s;

  // link control fields mirrored to user logic
  typedef struct packed {
    logic       autonomousBwIrqEnable;
    logic       bwMgmtIrqEnable;
    logic       clockPowerMgmtEnable;
    logic       extendedSynchOut;
    logic       sharedRefclkConfig;
    logic [1:0] activePowerMgmtControl;
  } dlm_link_ctrl_s;

  // device control 2 fields mirrored to user logic
  typedef struct packed {
    logic prefixForwardBlock;
    logic latencyReportEnable;
    logic idOrderRequestEnable;
  } dlm_dev_ctrl2_s;

  // error message requests towards the transmit side
  typedef struct packed {
    logic fatal;
    logic nonfatal;
    logic correctable;
  } dlm_msg_s;

  // one configuration write as seen by the mirror
  typedef struct packed {
    logic        valid;
    logic [6:0]  dwAddr;
    logic [3:0]  byteEn;
    logic [31:0] data;
  } dlm_cfg_wr_s;

endpackage : dlm_pkg

`default_nettype wire

// file: dlm_user_model.sv
// dlm_user_model.sv - user logic beside the mirror: forms request
// attributes only within the limits that the mirrored fields allow.
// assumes mirror outputs on ref_clk; the bench checks every request.
`timescale 1ns/1ns
`default_nettype none

module dlm_user_model (
  input  wire logic                    ref_clk,    // clock
  input  wire logic                    arst_n,     // async reset
  input  wire dlm_pkg::dlm_dev_ctrl_s  devCtrl,    // device control
  input  wire logic                    idoEn,      // ido mirror
  input  wire logic                    prefixBlk,  // prefix block
  input  wire dlm_pkg::dlm_link_ctrl_s link_control_reg,   // link control
  input  wire logic [1:0]              bwStatusSet, // bw status sets
  output logic [7:0]                   reqTag,     // request tag
  output logic [3:0]                   reqAttr,    // ido ro ns prefix
  output logic [12:0]                  reqPayload, // payload bytes
  output logic [12:0]                  reqReadLen, // read bytes
  output logic                         reqPhantom, // phantom use
  output logic                         clkReqUse,  // clock request
  output logic                         bwIrq       // bandwidth interrupt
);

  logic [7:0] wish_q;
  logic [7:0] wish_d;

  // ------------------------------------------------------------
  // wish counter
  // ------------------------------------------------------------
  // next wish, a new mix of attributes every cycle
  always_comb begin
    wish_d = wish_q + 8'h01;
  end

  // register the wish
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wish_q <= 8'h00;
    end else begin
      wish_q <= wish_d;
    end
  end

  // ------------------------------------------------------------
  // requests inside the mirrored limits
  // ------------------------------------------------------------
  // short tags unless wide tags are on; the mirror never checks them
  assign reqTag     = devCtrl.wideTagEnable ? wish_q
                                            : {3'h0, wish_q[4:0]};
  assign reqAttr[3] = idoEn & wish_q[0];
  assign reqAttr[2] = devCtrl.relaxedOrderEnable & wish_q[1];
  assign reqAttr[1] = devCtrl.noSnoopEnable & wish_q[2];
  assign reqAttr[0] = !prefixBlk & wish_q[3];
  assign reqPayload = 13'h0080 << devCtrl.maxPayloadSize;
  assign reqReadLen = 13'h0080 << devCtrl.maxReadRequestSize;
  assign reqPhantom = devCtrl.phantomFunctionEnable & wish_q[4];
  assign clkReqUse  = link_control_reg.clockPowerMgmtEnable;
  // the mirror raises no bandwidth interrupt, so user logic does
  assign bwIrq      = |(bwStatusSet & {link_control_reg.autonomousBwIrqEnable,
                                       link_control_reg.bwMgmtIrqEnable});

endmodule // dlm_user_model

`default_nettype wire

// file: test_pcie_device_link_control_mirror.sv
// test_pcie_device_link_control_mirror.sv - random and corner writes,
// error events and link levels, each cycle checked against a shadow.
// assumes dlm_pkg is compiled first and dlm_defs.svh is on the path.
`timescale 1ns/1ns
`default_nettype none
`include "dlm_defs.svh"

module test_pcie_device_link_control_mirror;
  logic                    ref_clk, arst_n, rootPortMode;
  logic                    linkExitingL0s, linkInRecovery;
  logic                    idOrderRequestEnable, latencyReportEnable;
  logic                    prefixForwardBlock, l0sEntryAllowed;
  logic                    extraOrderedSets, expL0s, expExt;
  logic [2:0]              expCtrl2;
  dlm_pkg::dlm_cfg_wr_s    cfgWr;
  dlm_pkg::dlm_err_s       errEvent, devStatus, expStatus;
  dlm_pkg::dlm_dev_ctrl_s  devCtrl, expCtrl;
  dlm_pkg::dlm_link_ctrl_s link_control_reg, expLink;
  dlm_pkg::dlm_msg_s       errMsgSend, expMsg;
  logic [7:0]              reqTag;
  logic [3:0]              reqAttr;
  logic [12:0]             reqPayload, reqReadLen;
  logic [1:0]              bwStatus;
  logic                    reqPhantom, clkReqUse, bwIrq;
  int                      err_count, n_compared, cycles;
  localparam logic [6:0]   DcAddr = `DLM_CAP_BASE_DW + `DLM_DEVCTRL_DW;
  localparam logic [6:0]   LcAddr = `DLM_CAP_BASE_DW + `DLM_LINK_CONTROL_REG_DW;

  dlm_link_control_mirror uut (.ref_clk(ref_clk), .arst_n(arst_n),
    .cfgWr(cfgWr), .errEvent(errEvent), .rootPortMode(rootPortMode),
    .linkExitingL0s(linkExitingL0s), .linkInRecovery(linkInRecovery),
    .idOrderRequestEnable(idOrderRequestEnable),
    .latencyReportEnable(latencyReportEnable),
    .prefixForwardBlock(prefixForwardBlock), .devCtrl(devCtrl),
    .devStatus(devStatus), .link_control_reg(link_control_reg), .errMsgSend(errMsgSend),
    .l0sEntryAllowed(l0sEntryAllowed), .extraOrderedSets(extraOrderedSets));

  dlm_user_model userApp (.ref_clk(ref_clk), .arst_n(arst_n),
    .devCtrl(devCtrl), .idoEn(idOrderRequestEnable),
    .prefixBlk(prefixForwardBlock), .link_control_reg(link_control_reg),
    .bwStatusSet(bwStatus), .reqTag(reqTag), .reqAttr(reqAttr),
    .reqPayload(reqPayload), .reqReadLen(reqReadLen),
    .reqPhantom(reqPhantom), .clkReqUse(clkReqUse), .bwIrq(bwIrq));

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  // 50 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // about 1710 cycles expected
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  // shadow back to the reset defaults
  task automatic exp_reset();
    expCtrl = `DLM_DEVCTRL_RST;
    {expStatus, expLink, expCtrl2, expMsg, expL0s, expExt} = '0;
  endtask

  // largest size in bytes that a size code allows
  function automatic int size_bytes(input logic [2:0] code);
    return 128 << code;
  endfunction

  // mirrors against the shadow, requests against the shadowed limits
  task automatic check_all();
    logic [3:0] okAttr;
    logic       bwExp;
    okAttr = {expCtrl2[0], expCtrl.relaxedOrderEnable,
              expCtrl.noSnoopEnable, !expCtrl2[2]};
    bwExp = |(bwStatus & {expLink.autonomousBwIrqEnable,
                          expLink.bwMgmtIrqEnable});
    check("devCtrl", 32'(expCtrl),
          32'(devCtrl));
    check("devStatus", 32'(expStatus), 32'(devStatus));
    check("link_control_reg", 32'(expLink), 32'(link_control_reg));
    check("ctrl2", 32'(expCtrl2), 32'({prefixForwardBlock,
          latencyReportEnable, idOrderRequestEnable}));
    check("reqTag", 32'h0,
          32'(expCtrl.wideTagEnable ? 3'h0 : reqTag[7:5]));
    check("reqAttr", 32'h0, 32'(reqAttr & ~okAttr));
    check("reqPayload", 32'h0,
          32'(reqPayload > size_bytes(expCtrl.maxPayloadSize)));
    check("reqReadLen", 32'h0,
          32'(reqReadLen > size_bytes(expCtrl.maxReadRequestSize)));
    check("reqPhantom", 32'h0,
          32'(reqPhantom & !expCtrl.phantomFunctionEnable));
    check("clkReqUse", 32'h0,
          32'(clkReqUse & !expLink.clockPowerMgmtEnable));
    check("bwIrq", 32'(bwExp), 32'(bwIrq));
    check("errMsgSend", 32'(expMsg), 32'(errMsgSend));
    check("l0s", 32'(expL0s), 32'(l0sEntryAllowed));
    check("extraOs", 32'(expExt), 32'(extraOrderedSets));
  endtask

  // one cycle: drive, let the edge pass, update the shadow, compare
  task automatic step(input dlm_pkg::dlm_cfg_wr_s w,
                      input dlm_pkg::dlm_err_s ev);
    dlm_pkg::dlm_dev_ctrl_s c;
    logic [6:0]             rel;
    logic [31:0]            d;
    logic                   rp;
    c = expCtrl;
    cfgWr = w;
    errEvent = ev;
    rootPortMode = 1'($urandom_range(1));
    linkExitingL0s = 1'($urandom_range(1));
    linkInRecovery = 1'($urandom_range(1));
    bwStatus = 2'($urandom);
    @(posedge ref_clk);
    #1;
    d = w.data;
    rel = w.dwAddr - `DLM_CAP_BASE_DW;
    rp = rootPortMode;
    expL0s = expLink.activePowerMgmtControl == `DLM_ASPM_L0S;
    expExt = expLink.extendedSynchOut & (linkExitingL0s | linkInRecovery);
    expMsg.fatal = ev.fatalSeenStatus & c.fatalReportEnable & !rp;
    expMsg.nonfatal = (ev.nonfatalSeenStatus | ev.unsupportedSeenStatus
      & c.unsupportedReportEnable) & c.nonfatalReportEnable & !rp;
    expMsg.correctable = ev.correctableSeenStatus
      & c.correctableReportEnable & !rp;
    if (w.valid && rel == `DLM_DEVCTRL_DW) begin
      if (w.byteEn[0]) expCtrl[7:0] = d[7:0];
      if (w.byteEn[1]) expCtrl[14:8] = {d[14:11], 1'b0, d[9:8]};
      if (w.byteEn[2]) expStatus = expStatus & ~d[19:16];
    end
    expStatus = expStatus | ev;
    if (w.valid && rel == `DLM_LINK_CONTROL_REG_DW && w.byteEn[0])
      expLink[3:0] = {d[7:6], d[1:0]};
    if (w.valid && rel == `DLM_LINK_CONTROL_REG_DW && w.byteEn[1])
      expLink[6:4] = {d[11:10], d[8]};
    if (w.valid && rel == `DLM_DEVCTRL2_DW && w.byteEn[1])
      expCtrl2 = {d[15], d[10], d[8]};
    check_all();
  endtask

  function automatic dlm_pkg::dlm_cfg_wr_s rnd_wr();
    dlm_pkg::dlm_cfg_wr_s w;
    logic [6:0] rels [4];
    rels = '{`DLM_DEVCTRL_DW, `DLM_LINK_CONTROL_REG_DW, `DLM_DEVCTRL2_DW, 7'h05};
    w.valid = 1'($urandom_range(1));
    w.dwAddr = `DLM_CAP_BASE_DW + rels[$urandom_range(3)];
    w.byteEn = 4'($urandom);
    w.data = $urandom;
    return w;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(61506));
    {arst_n, cfgWr, errEvent, rootPortMode} = '0;
    {linkExitingL0s, linkInRecovery, bwStatus} = '0;
    {err_count, n_compared, cycles} = '0;
    exp_reset();
    repeat (5) @(posedge ref_clk);
    #1;
    check_all();
    arst_n = 1'b1;
    // wide tag only, then all enables and every event, then clear vs set
    step('{1'b1, DcAddr, 4'h3, 32'h100}, '0);
    step('{1'b1, DcAddr, 4'h1, 32'hF}, 4'hF);
    step('{1'b1, DcAddr, 4'h4, 32'hF0000}, 4'h2);
    step('{1'b1, LcAddr, 4'h3, 32'hFFC1}, 4'h8);
    repeat (1500) step(rnd_wr(), 4'($urandom) & 4'($urandom));
    // reset in mid-run brings the defaults back
    arst_n = 1'b0;
    @(posedge ref_clk);
    #1;
    exp_reset();
    check_all();
    arst_n = 1'b1;
    repeat (200) step(rnd_wr(), 4'($urandom) & 4'($urandom));
    close_out();
  end

endmodule // test_pcie_device_link_control_mirror

`default_nettype wire
